//--- mcgm_global_mode_status.sv
// Global memory mode settings, cycle strobe timing, parity and error status.
`timescale 1ns/1ps

module mcgm_global_mode_status
  import mcgm_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Register port.
  input wire logic [MCGM_ADDR_W-1:0] reg_addr,
  input wire logic [MCGM_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [MCGM_DATA_W-1:0] reg_rdata,
  // Cycle request from the bank decoder.
  input wire logic transfer_start_strobe,
  input wire mcgm_cycle_t cycle_info,
  input wire mcgm_bank_attr_t bank_attr,
  input wire logic address_strobe_in,
  // Address paths.
  input wire logic [ADDR_W-1:0] row_addr,
  input wire logic [ADDR_W-1:0] col_addr,
  output logic [ADDR_W-1:0] mem_addr,
  // Data and parity.
  input wire logic [MCGM_DATA_W-1:0] wr_data,
  input wire logic [MCGM_DATA_W-1:0] rd_data,
  input wire logic [3:0] rd_parity,
  output logic [3:0] wr_parity,
  // Memory strobes.
  output logic [MCGM_NUM_BANKS-1:0] bank_select,
  output logic row_strobe,
  output logic col_strobe,
  output logic data_size_ack,
  output logic row_col_select_out,
  // Error signalling.
  output logic bus_fault,
  output logic parity_fault_out
);

  // Parity of each byte lane, inverted for odd parity.
  function automatic logic [3:0] lane_parity(input logic [31:0] d, input logic odd);
    logic [3:0] p;
    p = '0;
    for (int i = 0; i < 4; i++) begin
      p[i] = (^d[8*i +: 8]) ^ odd;
    end
    return p;
  endfunction : lane_parity

  logic [31:0] gmr_q;
  logic [MCGM_STAT_W-1:0] stat_q;
  logic [MCGM_STAT_W-1:0] stat_d;
  logic bus_sync_timing_mode_q;
  logic [MCGM_DATA_W-1:0] rdata_q;
  mcgm_state_t st_q;
  mcgm_state_t st_d;
  mcgm_cycle_t cyc_q;
  mcgm_bank_attr_t attr_q;
  logic [MCGM_WAIT_W-1:0] wcnt_q;
  logic [MCGM_WAIT_W-1:0] wcnt_d;
  logic [MCGM_DLY_W-1:0] dly_q;
  logic [MCGM_DLY_W-1:0] dly_d;
  logic as_s1_q;
  logic as_s2_q;
  logic bus_fault_q;
  logic [3:0] wr_parity_q;
  logic [ADDR_W-1:0] mem_addr_q;

  // Mode fields.
  wire logic mode_sync = gmr_q[MCGM_SYNC_BIT];
  wire logic mode_odd = gmr_q[MCGM_ODD_BIT];
  wire logic mode_parity_fault_bus_error_en = gmr_q[MCGM_PARITY_FAULT_BUS_ERROR_EN_BIT];
  wire logic mode_tss = gmr_q[MCGM_TSS_BIT];
  wire logic mode_ncs = gmr_q[MCGM_NCS_BIT];
  wire logic mode_internal_addr_mux_en = gmr_q[MCGM_INTERNAL_ADDR_MUX_EN_BIT];

  // Register decode.
  wire logic hit_gmr = reg_addr == MCGM_GMR_OFF;
  wire logic hit_stat = reg_addr == MCGM_STAT_OFF;
  wire logic hit_mcr = reg_addr == MCGM_MCR_OFF;
  wire logic [MCGM_DATA_W-1:0] rd_mux =
    hit_gmr ? gmr_q :
    hit_stat ? {16'h0000, stat_q} :
    hit_mcr ? {31'h0000_0000, bus_sync_timing_mode_q} : 32'h0000_0000;

  // Timing class of the starting cycle.
  wire logic new_ext_as = cycle_info.ext_master & ~cycle_info.ext_late_type;
  wire logic new_async = new_ext_as & ~mode_sync;
  wire logic new_honour = ~cycle_info.ext_late_type & ~new_async;
  wire logic new_cpu_block = mode_ncs & (cycle_info.func_code == MCGM_CPU_SPACE_FC);
  wire logic new_wp_block = bank_attr.write_protect & cycle_info.write;
  wire logic start = transfer_start_strobe & (st_q == MCGM_IDLE);
  wire logic start_go = start & ~new_cpu_block & ~new_wp_block;
  wire logic [MCGM_DLY_W-1:0] new_dly =
    MCGM_DLY_W'(cycle_info.ext_late_type & mode_tss) +
    MCGM_DLY_W'(new_honour & bank_attr.relaxed_cycle_start);
  wire logic [MCGM_WAIT_W-1:0] new_wait =
    MCGM_WAIT_W'(bank_attr.cycle_wait_count) +
    MCGM_WAIT_W'(new_async & ~bank_attr.dram & bank_attr.external_master_extra_wait);

  // Timing class of the running cycle.
  wire logic cur_ext_as = cyc_q.ext_master & ~cyc_q.ext_late_type;
  wire logic cur_async = cur_ext_as & ~mode_sync;
  // Mode 0 synchronises the external strobe through two flops first; mode 1 uses it directly.
  wire logic as_seen = bus_sync_timing_mode_q ? address_strobe_in : as_s2_q;
  wire logic neg_ok = ~cur_async | as_seen;
  wire logic in_cycle = (st_q == MCGM_ROW) | (st_q == MCGM_WAIT) |
                        (st_q == MCGM_ACK) | (st_q == MCGM_HOLD);
  wire logic in_ack = (st_q == MCGM_ACK) | (st_q == MCGM_HOLD);
  wire logic early_neg = (st_q == MCGM_ACK) & ~cur_async & ~cyc_q.ext_late_type &
                         cyc_q.write & attr_q.early_select_negate;
  wire logic sram_sel = ~attr_q.dram & in_cycle & neg_ok & ~early_neg;

  // Parity check on the acknowledge edge of a read.
  wire logic par_allowed = ~cur_ext_as | mode_sync;
  wire logic par_check = (st_q == MCGM_ACK) & ~cyc_q.write & attr_q.parity_check_en &
                         par_allowed;
  wire logic par_err = par_check & (|(lane_parity(rd_data, mode_odd) ^ rd_parity));
  wire logic [MCGM_NUM_BANKS-1:0] bank_onehot = MCGM_NUM_BANKS'(1) << cyc_q.bank;

  // Next state of the memory cycle.
  always_comb begin
    st_d = st_q;
    wcnt_d = wcnt_q;
    dly_d = dly_q;
    unique case (st_q)
      MCGM_IDLE: begin
        if (start_go) begin
          wcnt_d = new_wait;
          dly_d = new_dly;
          st_d = (new_dly != '0) ? MCGM_DLY : MCGM_ROW;
        end
      end
      MCGM_DLY: begin
        dly_d = dly_q - MCGM_DLY_W'(1);
        if (dly_q == MCGM_DLY_W'(1)) begin
          st_d = MCGM_ROW;
        end
      end
      MCGM_ROW: begin
        st_d = (wcnt_q == '0) ? MCGM_ACK : MCGM_WAIT;
      end
      MCGM_WAIT: begin
        wcnt_d = wcnt_q - MCGM_WAIT_W'(1);
        if (wcnt_q == MCGM_WAIT_W'(1)) begin
          st_d = MCGM_ACK;
        end
      end
      MCGM_ACK: begin
        st_d = (cur_async & as_seen) ? MCGM_HOLD : MCGM_IDLE;
      end
      MCGM_HOLD: begin
        if (~as_seen) begin
          st_d = MCGM_IDLE;
        end
      end
      default: begin
        st_d = MCGM_IDLE;
      end
    endcase
  end

  // Status updates; a new fault wins over a clear in the same cycle.
  always_comb begin
    stat_d = stat_q;
    if (reg_wr & hit_stat) begin
      stat_d = stat_q & ~reg_wdata[MCGM_STAT_W-1:0];
    end
    if (start & new_wp_block) begin
      stat_d[MCGM_WRITE_PROTECT_FAULT_BIT] = 1'b1;
    end
    if (par_err) begin
      stat_d[MCGM_NUM_BANKS-1:0] = stat_d[MCGM_NUM_BANKS-1:0] | bank_onehot;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      gmr_q <= MCGM_GMR_RST;
      stat_q <= MCGM_STAT_RST;
      bus_sync_timing_mode_q <= MCGM_BUS_SYNC_TIMING_MODE_RST;
      rdata_q <= '0;
    end else begin
      if (reg_wr & hit_gmr) begin
        gmr_q <= reg_wdata & MCGM_GMR_MASK;
      end
      if (reg_wr & hit_mcr) begin
        bus_sync_timing_mode_q <= reg_wdata[MCGM_BUS_SYNC_TIMING_MODE_BIT];
      end
      stat_q <= stat_d;
      rdata_q <= reg_rd ? rd_mux : '0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_q <= MCGM_IDLE;
      cyc_q <= '0;
      attr_q <= '0;
      wcnt_q <= '0;
      dly_q <= '0;
    end else begin
      st_q <= st_d;
      wcnt_q <= wcnt_d;
      dly_q <= dly_d;
      if (start) begin
        cyc_q <= cycle_info;
        attr_q <= bank_attr;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      as_s1_q <= 1'b0;
      as_s2_q <= 1'b0;
      bus_fault_q <= 1'b0;
      wr_parity_q <= '0;
      mem_addr_q <= '0;
    end else begin
      as_s1_q <= address_strobe_in;
      as_s2_q <= as_s1_q;
      bus_fault_q <= par_err & mode_parity_fault_bus_error_en & ~cyc_q.ext_master;
      wr_parity_q <= lane_parity(wr_data, mode_odd);
      // Column address once the row/column select has gone low.
      mem_addr_q <= (mode_internal_addr_mux_en & attr_q.dram & ~row_col_select_out) ? col_addr : row_addr;
    end
  end

  // Outputs; the bank parity bits of the status register drive parity_fault_out.
  assign reg_rdata = rdata_q;
  assign bank_select = sram_sel ? bank_onehot : '0;
  assign row_strobe = attr_q.dram & in_cycle;
  assign col_strobe = attr_q.dram & in_ack & neg_ok;
  assign data_size_ack = in_ack & neg_ok;
  assign row_col_select_out = ~(attr_q.dram & ((st_q == MCGM_WAIT) | in_ack));
  assign mem_addr = mem_addr_q;
  assign wr_parity = wr_parity_q;
  assign bus_fault = bus_fault_q;
  assign parity_fault_out = |stat_q[MCGM_NUM_BANKS-1:0];

endmodule : mcgm_global_mode_status

//--- mcgm_pkg.sv
// Package with register map, field positions, types and states of the memory mode/status block.
package mcgm_pkg;

  // Register map and bus widths.
  localparam int MCGM_ADDR_W = 8;
  localparam int MCGM_DATA_W = 32;
  localparam logic [7:0] MCGM_GMR_OFF = 8'h00;
  localparam logic [7:0] MCGM_STAT_OFF = 8'h04;
  localparam logic [7:0] MCGM_MCR_OFF = 8'h08;

  // Global mode field positions.
  localparam int MCGM_SYNC_BIT = 11;
  localparam int MCGM_ODD_BIT = 10;
  localparam int MCGM_PARITY_FAULT_BUS_ERROR_EN_BIT = 9;
  localparam int MCGM_TSS_BIT = 8;
  localparam int MCGM_NCS_BIT = 7;
  localparam int MCGM_INTERNAL_ADDR_MUX_EN_BIT = 6;
  localparam logic [31:0] MCGM_GMR_MASK = 32'h0000_0fc0;

  // Module configuration field position.
  localparam int MCGM_BUS_SYNC_TIMING_MODE_BIT = 0;

  // Status register layout.
  localparam int MCGM_WRITE_PROTECT_FAULT_BIT = 8;
  localparam int MCGM_NUM_BANKS = 8;
  localparam int MCGM_BANK_W = 3;
  localparam int MCGM_STAT_W = 16;

  // Values after reset.
  localparam logic [31:0] MCGM_GMR_RST = 32'h0000_0000;
  localparam logic [MCGM_STAT_W-1:0] MCGM_STAT_RST = 16'h0000;
  localparam logic MCGM_BUS_SYNC_TIMING_MODE_RST = 1'b0;

  // Function code of a CPU space cycle.
  localparam logic [3:0] MCGM_CPU_SPACE_FC = 4'h7;

  // Cycle counts.
  localparam int MCGM_WAIT_W = 5;
  localparam int MCGM_DLY_W = 2;

  // Attributes of the bank that the current cycle hits.
  typedef struct packed {
    logic dram;
    logic write_protect;
    logic parity_check_en;
    logic early_select_negate;
    logic relaxed_cycle_start;
    logic external_master_extra_wait;
    logic [3:0] cycle_wait_count;
  } mcgm_bank_attr_t;

  // Description of a cycle at its start.
  typedef struct packed {
    logic ext_master;
    logic ext_late_type;
    logic write;
    logic [3:0] func_code;
    logic [MCGM_BANK_W-1:0] bank;
  } mcgm_cycle_t;

  // Memory cycle states, Gray coded along the path.
  typedef enum logic [2:0] {
    MCGM_IDLE = 3'b000,
    MCGM_DLY = 3'b001,
    MCGM_ROW = 3'b011,
    MCGM_WAIT = 3'b010,
    MCGM_ACK = 3'b110,
    MCGM_HOLD = 3'b111
  } mcgm_state_t;

endpackage : mcgm_pkg

//--- mcgm_checker.sv
// Concurrent checks on the ports of the memory mode and status block.
`timescale 1ns/1ps
module mcgm_checker
  import mcgm_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Register port.
  input wire logic [MCGM_ADDR_W-1:0] reg_addr,
  input wire logic [MCGM_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  // Cycle request.
  input wire logic transfer_start_strobe,
  input wire mcgm_cycle_t cycle_info,
  // Data and strobes.
  input wire logic [MCGM_DATA_W-1:0] wr_data,
  input wire logic [3:0] wr_parity,
  input wire logic [MCGM_NUM_BANKS-1:0] bank_select,
  input wire logic row_strobe,
  input wire logic col_strobe,
  input wire logic data_size_ack,
  input wire logic row_col_select_out,
  // Errors.
  input wire logic bus_fault,
  input wire logic parity_fault_out
);
  logic ncs_q;
  logic odd_q;
  wire quiet = !(|bank_select) && !row_strobe && !data_size_ack;
  wire [3:0] lp = {^wr_data[31:24], ^wr_data[23:16], ^wr_data[15:8], ^wr_data[7:0]};
  wire st_wr = reg_wr && reg_addr == MCGM_STAT_OFF;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ncs_q <= 1'b0;
      odd_q <= 1'b0;
    end else if (reg_wr && reg_addr == MCGM_GMR_OFF) begin
      ncs_q <= reg_wdata[MCGM_NCS_BIT];
      odd_q <= reg_wdata[MCGM_ODD_BIT];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_start; transfer_start_strobe && quiet; endsequence
  sequence s_dead4; quiet [*4]; endsequence
  property p_ncs; s_start ##0 (ncs_q && cycle_info.func_code == 4'h7) |=> s_dead4; endproperty
  a_ncs: assert property (p_ncs) else $error("cpu space cycle selected");
  property p_bf; bus_fault |-> $past(data_size_ack) && !cycle_info.ext_master; endproperty
  a_bf: assert property (p_bf) else $error("bus fault without internal read");
  property p_prise; $rose(parity_fault_out) |-> $past(data_size_ack); endproperty
  a_prise: assert property (p_prise) else $error("parity fault without cycle");
  property p_phold; parity_fault_out && !(st_wr && |reg_wdata[7:0]) |=> parity_fault_out; endproperty
  a_phold: assert property (p_phold) else $error("parity fault dropped");
  property p_clr; st_wr && reg_wdata[7:0] == 8'hff && !data_size_ack |=> !parity_fault_out; endproperty
  a_clr: assert property (p_clr) else $error("status not cleared");
  property p_par; $past(rstn) |-> wr_parity == ($past(lp) ^ {4{$past(odd_q)}}); endproperty
  a_par: assert property (p_par) else $error("write parity wrong");
  property p_row_col_select_out; !row_col_select_out |-> row_strobe; endproperty
  a_row_col_select_out: assert property (p_row_col_select_out) else $error("column select outside cycle");
  property p_col; $rose(col_strobe) |-> $past(row_strobe) && row_strobe; endproperty
  a_col: assert property (p_col) else $error("column strobe before row");
endmodule : mcgm_checker

//--- mcgm_mem_model.sv
// Behavioural memory bank holding one word and its lane parity.
`timescale 1ns/1ps
module mcgm_mem_model
  import mcgm_pkg::*;
(
  // Clock.
  input wire logic clock,
  // Strobes and cycle.
  input wire logic [MCGM_NUM_BANKS-1:0] bank_select,
  input wire logic row_strobe,
  input wire logic data_size_ack,
  input wire mcgm_cycle_t cycle_info,
  // Data.
  input wire logic [MCGM_DATA_W-1:0] wr_data,
  input wire logic [3:0] wr_parity,
  output logic [MCGM_DATA_W-1:0] rd_data,
  output logic [3:0] rd_parity
);
  logic [MCGM_DATA_W-1:0] word_q;
  logic [3:0] par_q;
  wire act = |bank_select || row_strobe;
  // Unselected lines show the inverse of the stored value.
  assign rd_data = act ? word_q : ~word_q;
  assign rd_parity = act ? par_q : ~par_q;
  always_ff @(posedge clock) begin
    if (data_size_ack && cycle_info.write) begin
      word_q <= wr_data;
      par_q <= wr_parity;
    end
  end
endmodule : mcgm_mem_model

//--- tb.sv
// Self-checking bench of the memory mode and status block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
  import mcgm_pkg::*;
  localparam int AW = 12;
  logic clock = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic transfer_start_strobe = 1'b0, address_strobe_in = 1'b0;
  logic [MCGM_ADDR_W-1:0] reg_addr = '0;
  logic [MCGM_DATA_W-1:0] reg_wdata = '0, wr_data = '0, reg_rdata, rd_data;
  logic [AW-1:0] row_addr = '0, col_addr = '0, mem_addr;
  mcgm_cycle_t cycle_info = '0;
  mcgm_bank_attr_t bank_attr = '0;
  logic [3:0] rd_parity, wr_parity;
  logic [MCGM_NUM_BANKS-1:0] bank_select;
  logic row_strobe, col_strobe, data_size_ack, row_col_select_out, bus_fault, parity_fault_out;
  int failures = 0, n_tests = 0, seed = 32'h7928;
  logic [31:0] exp_q[$];
  logic [31:0] e_m, r;
  logic rd_q = 1'b0;
  always #2.5 clock = ~clock;
  mcgm_global_mode_status #(.ADDR_W(AW)) DUT (.*);
  mcgm_mem_model u_mem (.*);
  always @(posedge clock) begin
    if (rd_q) begin
      e_m = exp_q.pop_front();
      `CHK("reg_rdata", e_m, reg_rdata)
    end
    rd_q <= reg_rd;
  end
  task automatic final_report;
    $display("Checks %0d, failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) exp_q.push_back(d);
    @(posedge clock);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : acc
  function automatic mcgm_cycle_t cy(input int e, t, w, f, b);
    cy = '{e[0], t[0], w[0], f[3:0], b[2:0]};
  endfunction : cy
  function automatic mcgm_bank_attr_t at(input int d, wp, pe, rl, em);
    at = '{d[0], wp[0], pe[0], 1'b0, rl[0], em[0], 4'h1};
  endfunction : at
  task automatic mem(input mcgm_cycle_t ci, input mcgm_bank_attr_t ba, input int lat,
                     input logic bf_e, input logic hold, input logic gx);
    int n;
    logic bf;
    bf = 1'b0;
    @(posedge clock);
    transfer_start_strobe <= 1'b1;
    cycle_info <= ci;
    bank_attr <= ba;
    address_strobe_in <= ci.ext_master;
    wr_data <= $random(seed);
    row_addr <= AW'($random(seed));
    col_addr <= AW'($random(seed));
    @(posedge clock);
    transfer_start_strobe <= 1'b0;
    #1;
    n = 1;
    while (data_size_ack !== 1'b1 && n <= 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n > 20 && lat != 0) begin
      failures++;
      final_report();
    end
    `CHK("ack_latency", lat, (n > 20) ? 0 : n)
    if (n <= 20) `CHK("mem_addr", gx ? col_addr : row_addr, mem_addr)
    for (int k = 0; k < 8; k++) begin
      @(posedge clock);
      if (k == 1) address_strobe_in <= 1'b0;
      #1;
      bf |= bus_fault;
      if (k == 0 && hold) `CHK("ack_hold", 1'b1, data_size_ack)
      if (k == 0 && !hold) `CHK("ack_drop", 1'b0, data_size_ack)
    end
    `CHK("bus_fault", bf_e, bf)
    `CHK("idle", 1'b0, data_size_ack | row_strobe | (|bank_select))
  endtask : mem
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    acc(0, MCGM_GMR_OFF, 32'h0);
    acc(0, MCGM_STAT_OFF, 32'h0);
    acc(0, MCGM_MCR_OFF, 32'h0);
    r = $random(seed);
    acc(1, MCGM_GMR_OFF, r);
    acc(0, MCGM_GMR_OFF, r & MCGM_GMR_MASK);
    acc(1, 8'h0c, r);
    acc(0, 8'h0c, 32'h0);
    acc(1, MCGM_MCR_OFF, 32'h1);
    acc(0, MCGM_MCR_OFF, 32'h1);
    acc(1, MCGM_GMR_OFF, 32'h0e40);
    mem(cy(0, 0, 1, 5, 2), at(1, 0, 1, 0, 0), 3, 0, 0, 1);
    acc(1, MCGM_GMR_OFF, 32'h0a00);
    mem(cy(0, 0, 0, 5, 2), at(1, 0, 1, 0, 0), 3, 1, 0, 0);
    acc(0, MCGM_STAT_OFF, 32'h4);
    acc(1, MCGM_STAT_OFF, 32'h0);
    acc(0, MCGM_STAT_OFF, 32'h4);
    acc(1, MCGM_STAT_OFF, 32'h1ff);
    acc(0, MCGM_STAT_OFF, 32'h0);
    mem(cy(1, 0, 0, 5, 5), at(1, 0, 1, 0, 0), 3, 0, 0, 0);
    acc(0, MCGM_STAT_OFF, 32'h20);
    acc(1, MCGM_STAT_OFF, 32'h1ff);
    mem(cy(0, 0, 0, 5, 3), at(1, 0, 0, 0, 0), 3, 0, 0, 0);
    acc(0, MCGM_STAT_OFF, 32'h0);
    mem(cy(0, 0, 1, 5, 1), at(0, 1, 0, 0, 0), 0, 0, 0, 0);
    acc(0, MCGM_STAT_OFF, 32'h100);
    acc(1, MCGM_STAT_OFF, 32'h1ff);
    acc(1, MCGM_GMR_OFF, 32'h0880);
    mem(cy(0, 0, 0, 7, 0), at(0, 0, 0, 0, 0), 0, 0, 0, 0);
    mem(cy(0, 0, 0, 6, 0), at(0, 0, 0, 0, 0), 3, 0, 0, 0);
    acc(1, MCGM_GMR_OFF, 32'h0800);
    mem(cy(0, 0, 0, 7, 0), at(0, 0, 0, 0, 0), 3, 0, 0, 0);
    mem(cy(1, 1, 0, 5, 4), at(0, 0, 0, 0, 0), 3, 0, 0, 0);
    acc(1, MCGM_GMR_OFF, 32'h0900);
    mem(cy(1, 1, 0, 5, 4), at(0, 0, 0, 0, 0), 4, 0, 0, 0);
    mem(cy(0, 0, 0, 5, 4), at(0, 0, 0, 1, 0), 4, 0, 0, 0);
    acc(1, MCGM_MCR_OFF, 32'h0);
    acc(1, MCGM_GMR_OFF, 32'h0);
    mem(cy(1, 0, 0, 5, 4), at(0, 0, 0, 1, 0), 3, 0, 1, 0);
    mem(cy(1, 0, 0, 5, 4), at(0, 0, 0, 0, 1), 4, 0, 1, 0);
    mem(cy(1, 0, 0, 5, 6), at(1, 0, 1, 0, 0), 3, 0, 1, 0);
    acc(0, MCGM_STAT_OFF, 32'h0);
    repeat (3) @(posedge clock);
    final_report();
  end
endmodule : tb
bind mcgm_global_mode_status mcgm_checker u_chk (.*);
